// file: hdl/csp_consts.svh
// Constants for the clock supervision and PLL setup block
// Functional notes
// - Detector off after reset until software enables it.
// - Detector inactive while main crystal enable is zero.
// - Detector enable turns on the slow RC oscillator.
// - Edge counter clears while slow RC low, counts while high.
// - Under eight main edges in a high phase is a failure.
// - Failure sets event flag; interrupt holds until status read.
// - Live failure status bit readable at any time.
// - Crystal main with PLL master: failure forces main clock.
// - Failure selects and re-enables the fast RC.
// - Switch takes two slow cycles from main, three from PLL.
// - Fault output holds until software writes the clear bit.
// - Monitor runs on reference; needs enable and RC select clear.
// - Four consecutive periods beyond ten percent raise the error.
// - Beyond ten percent always flagged; one to ten may be.
// - Error clears only with monitor off; may raise interrupt.
// - Crystal stable flag rises after programmed start-up time.
// - Count main edges over 16 slow cycles, then ready.
// - Divider 0 to 127; zero turns divider and PLL off.
// - Multiplier 0 to 254, times field plus one; zero is off.
// - Lock rises after programmed slow cycles; rewrite drops it.
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
// Register byte offsets
`define CSP_OFS_MOR      5'h00
`define CSP_OFS_MCKR     5'h04
`define CSP_OFS_PLL      5'h08
`define CSP_OFS_SR       5'h0c
`define CSP_OFS_IER      5'h10
`define CSP_OFS_FOCR     5'h14
`define CSP_OFS_MCFR     5'h18
`define CSP_OFS_OCR      5'h1c
// Main oscillator register fields
`define CSP_MOR_XT_EN    0
`define CSP_MOR_RC_EN    3
`define CSP_MOR_XTST_LSB 8
`define CSP_MOR_XTST_MSB 15
`define CSP_MOR_XT_SEL   24
`define CSP_MOR_FD_EN    25
`define CSP_MOR_XTM_EN   26
`define CSP_MOR_RC_RST   1'b1
// PLL register fields
`define CSP_PLL_DIV_LSB  0
`define CSP_PLL_DIV_MSB  6
`define CSP_PLL_CNT_LSB  8
`define CSP_PLL_CNT_MSB  13
`define CSP_PLL_MUL_LSB  16
`define CSP_PLL_MUL_MSB  23
// Status / interrupt enable bits
`define CSP_SR_XT_STABLE 0
`define CSP_SR_LOCK      1
`define CSP_SR_SEL_DONE  16
`define CSP_SR_RC_STABLE 17
`define CSP_SR_FD_EVENT  18
`define CSP_SR_FD_STATUS 19
`define CSP_SR_FAULT     20
`define CSP_SR_XT_ERR    21
// Clear register bits
`define CSP_FOCR_FAULT   0
`define CSP_FOCR_XT_ERR  1
// Frequency counter fields
`define CSP_MCFR_RDY     16
// Oscillator calibration select field
`define CSP_OCR_SEL_MSB  2
// Clock select encodings
`define CSP_CSS_MAIN     2'h1
`define CSP_CSS_PLL      2'h2
// Timing and counts
`define CSP_CLK_HZ       50000000
`define CSP_CLK_NS       20
`define CSP_RC_SETTLE_NS 10000
`define CSP_XT32_HZ      32768
`define CSP_FD_MIN_EDGES 8
`define CSP_FREQ_WINDOW  16
`define CSP_XT_BAD_RUN   4
`define CSP_XTST_SHIFT   3
`endif

// file: hdl/csp_pkg.sv
// Types shared by the clock supervision block
package csp_pkg;
    // Failover sequence, Gray only on the steps into and out of FS_FORCE
    typedef enum logic [1:0] {
        FS_IDLE   = 2'b00,
        FS_FORCE  = 2'b01,
        FS_SWITCH = 2'b11
    } csp_fo_t;

    typedef struct packed {
        logic       xtm_en;
        logic       fd_en;
        logic       xt_sel;
        logic [7:0] xtst;
        logic       rc_en;
        logic       xt_en;
    } csp_mor_t;

    typedef struct packed {
        logic [7:0] mul;
        logic [5:0] cnt;
        logic [6:0] div;
    } csp_pll_t;
endpackage : csp_pkg

// file: hdl/csp_top.sv
// Clock supervision, frequency monitors and PLL setup registers
`timescale 1ns/100ps
`default_nettype none
`include "csp_consts.svh"

module csp_top
    import csp_pkg::*;
#(
    parameter int FD_MIN_EDGES = `CSP_FD_MIN_EDGES,
    parameter int FREQ_WINDOW  = `CSP_FREQ_WINDOW,
    parameter int XT_BAD_RUN   = `CSP_XT_BAD_RUN,
    parameter int REF_HZ       = `CSP_CLK_HZ
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // Register port
    input  wire logic [4:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [31:0] RDATA,
    output var  logic        IRQ,
    // Oscillator clocks, asynchronous
    input  wire logic        MAIN_CLK_IN,
    input  wire logic        SLOW_RC_IN,
    input  wire logic        XTAL32_IN,
    // Oscillator and clock selection controls
    output var  logic        MAIN_XTAL_EN,
    output var  logic        MAIN_SRC_CRYSTAL,
    output var  logic        FAST_RC_EN,
    output var  logic        SLOW_RC_EN,
    output var  logic [1:0]  MCK_SRC,
    output var  logic        PLL_EN,
    output var  logic [6:0]  PLL_DIV,
    output var  logic [7:0]  PLL_MUL,
    output var  logic        FAULT_OUT
);
    localparam int XT_NOM = REF_HZ / `CSP_XT32_HZ;
    localparam logic [11:0] XT_LO = 12'((XT_NOM * 9) / 10);
    localparam logic [11:0] XT_HI = 12'((XT_NOM * 11) / 10);
    localparam int RC_SETTLE_CYC =
        (`CSP_RC_SETTLE_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS;
    localparam logic [9:0] RC_SETTLE = 10'(RC_SETTLE_CYC);
    localparam logic [4:0] FD_MIN = 5'(FD_MIN_EDGES);
    localparam logic [4:0] FW_LAST = 5'(FREQ_WINDOW - 1);
    localparam logic [2:0] BAD_RUN = 3'(XT_BAD_RUN);

    generate
        if (FD_MIN_EDGES < 1 || FD_MIN_EDGES > 30)
            $error("FD_MIN_EDGES out of range");
        if (FREQ_WINDOW < 1 || FREQ_WINDOW > 32)
            $error("FREQ_WINDOW out of range");
        if (XT_BAD_RUN < 1 || XT_BAD_RUN > 7)
            $error("XT_BAD_RUN out of range");
        if (XT_NOM * 11 / 10 > 4000 || RC_SETTLE_CYC > 1023)
            $error("REF_HZ unsupported");
    endgenerate

    // Input synchronisers; third stage only feeds edge detection
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
        end else begin
            sync1 <= {XTAL32_IN, SLOW_RC_IN, MAIN_CLK_IN};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    wire main_rise = sync2[0] & ~sync3[0];
    wire slow_hi   = sync2[1];
    wire slow_rise = sync2[1] & ~sync3[1];
    wire slow_fall = ~sync2[1] & sync3[1];
    wire xt_rise   = sync2[2] & ~sync3[2];

    // Register strobes
    wire wr_mor  = WR && ADDR == `CSP_OFS_MOR;
    wire wr_mckr = WR && ADDR == `CSP_OFS_MCKR;
    wire wr_pll  = WR && ADDR == `CSP_OFS_PLL;
    wire wr_ier  = WR && ADDR == `CSP_OFS_IER;
    wire wr_focr = WR && ADDR == `CSP_OFS_FOCR;
    wire wr_mcfr = WR && ADDR == `CSP_OFS_MCFR;
    wire wr_ocr  = WR && ADDR == `CSP_OFS_OCR;
    wire rd_sr   = RD && ADDR == `CSP_OFS_SR;

    csp_mor_t   mor;
    csp_pll_t   pll;
    logic [1:0] clock_source_select;
    logic [2:0] ocr_sel;
    logic [31:0] ier;
    csp_fo_t    fo_state;

    wire csp_mor_t wr_mor_val = '{
        xtm_en: WDATA[`CSP_MOR_XTM_EN],
        fd_en:  WDATA[`CSP_MOR_FD_EN],
        xt_sel: WDATA[`CSP_MOR_XT_SEL],
        xtst:   WDATA[`CSP_MOR_XTST_MSB:`CSP_MOR_XTST_LSB],
        rc_en:  WDATA[`CSP_MOR_RC_EN],
        xt_en:  WDATA[`CSP_MOR_XT_EN]
    };

    // Failure detector
    wire fd_active = mor.fd_en & mor.xt_en;
    logic [4:0] fd_cnt;
    logic       fd_status;
    wire fd_sat      = fd_cnt == FD_MIN;
    wire window_fail = fd_active & slow_fall & (fd_cnt < FD_MIN);
    wire fo_tick     = slow_fall & fo_state != FS_IDLE;
    wire fo_force    = fo_tick & fo_state == FS_FORCE;
    wire fo_switch   = fo_tick & fo_state == FS_SWITCH;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !fd_active || !slow_hi)
            fd_cnt <= 5'h0;
        else if (main_rise && !fd_sat)
            fd_cnt <= fd_cnt + 5'h1;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !fd_active)
            fd_status <= 1'b0;
        else if (slow_fall)
            fd_status <= window_fail;
    end

    // Failure takes one window to see, then one or two more to switch
    csp_fo_t next_fo_state;
    assign next_fo_state =
        (fo_state == FS_IDLE && window_fail) ?
            ((mor.xt_sel && clock_source_select == `CSP_CSS_PLL) ? FS_FORCE : FS_SWITCH) :
        fo_force  ? FS_SWITCH :
        fo_switch ? FS_IDLE : fo_state;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            fo_state <= FS_IDLE;
        else
            fo_state <= next_fo_state;
    end

    // Main oscillator register; failover overrides software
    csp_mor_t next_mor;
    always_comb begin
        next_mor = wr_mor ? wr_mor_val : mor;
        if (fo_switch) begin
            next_mor.xt_sel = 1'b0;
            next_mor.rc_en  = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            mor       <= '0;
            mor.rc_en <= `CSP_MOR_RC_RST;
        end else begin
            mor <= next_mor;
        end
    end

    wire [1:0] next_css = fo_force ? `CSP_CSS_MAIN :
                          wr_mckr ? WDATA[1:0] : clock_source_select;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            clock_source_select <= `CSP_CSS_MAIN;
        else
            clock_source_select <= next_css;
    end

    // Sticky flags: set wins over clear
    logic fd_event;
    logic fault;
    logic xt_err;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            fd_event <= 1'b0;
            fault    <= 1'b0;
        end else begin
            fd_event <= window_fail | (fd_event & ~rd_sr);
            fault    <= window_fail |
                        (fault & ~(wr_focr & WDATA[`CSP_FOCR_FAULT]));
        end
    end

    // Crystal start-up: field counts eight slow cycles per step
    logic [10:0] xt_cnt;
    logic        xt_stable;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            xt_cnt    <= 11'h0;
            xt_stable <= 1'b0;
        end else if (wr_mor || !mor.xt_en) begin
            xt_cnt    <= {wr_mor_val.xtst, 3'h0};
            xt_stable <= 1'b0;
        end else if (xt_cnt != 11'h0) begin
            if (slow_rise)
                xt_cnt <= xt_cnt - 11'h1;
        end else begin
            xt_stable <= 1'b1;
        end
    end

    // Main source select applied on a slow clock edge
    logic sel_applied;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            sel_applied <= 1'b0;
        else if (slow_rise || fo_switch)
            sel_applied <= next_mor.xt_sel;
    end
    wire sel_done = sel_applied == mor.xt_sel;

    // Fast RC settling after enable or frequency change
    logic [9:0] rc_cnt;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || wr_ocr || !mor.rc_en)
            rc_cnt <= RC_SETTLE;
        else if (rc_cnt != 10'h0)
            rc_cnt <= rc_cnt - 10'h1;
    end
    wire rc_stable = rc_cnt == 10'h0;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ocr_sel <= 3'h0;
            ier     <= 32'h0;
        end else begin
            if (wr_ocr)
                ocr_sel <= WDATA[`CSP_OCR_SEL_MSB:0];
            if (wr_ier)
                ier <= WDATA;
        end
    end

    // Main clock frequency counter, restarted by a write
    logic        mf_arm;
    logic        mf_run;
    logic        mf_rdy;
    logic [15:0] mf_cnt;
    logic [4:0]  mf_slow;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || wr_mcfr) begin
            mf_arm  <= 1'b1;
            mf_run  <= 1'b0;
            mf_rdy  <= 1'b0;
            mf_cnt  <= 16'h0;
            mf_slow <= 5'h0;
        end else if (mf_arm && slow_rise) begin
            mf_arm <= 1'b0;
            mf_run <= 1'b1;
        end else if (mf_run) begin
            if (main_rise)
                mf_cnt <= mf_cnt + 16'h1;
            if (slow_rise) begin
                mf_slow <= mf_slow + 5'h1;
                if (mf_slow == FW_LAST) begin
                    mf_run <= 1'b0;
                    mf_rdy <= 1'b1;
                end
            end
        end
    end

    // PLL lock counter on slow clock
    wire pll_on = pll.div != 7'h0 && pll.mul != 8'h0;
    logic [5:0] lock_cnt;
    logic       locked;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pll      <= '0;
            lock_cnt <= 6'h0;
            locked   <= 1'b0;
        end else if (wr_pll) begin
            pll.div  <= WDATA[`CSP_PLL_DIV_MSB:`CSP_PLL_DIV_LSB];
            pll.mul  <= WDATA[`CSP_PLL_MUL_MSB:`CSP_PLL_MUL_LSB];
            pll.cnt  <= WDATA[`CSP_PLL_CNT_MSB:`CSP_PLL_CNT_LSB];
            lock_cnt <= WDATA[`CSP_PLL_CNT_MSB:`CSP_PLL_CNT_LSB];
            locked   <= 1'b0;
        end else if (!pll_on) begin
            locked <= 1'b0;
        end else if (lock_cnt != 6'h0) begin
            if (slow_rise)
                lock_cnt <= lock_cnt - 6'h1;
        end else begin
            locked <= 1'b1;
        end
    end

    // Slow crystal period monitor on the reference clock
    wire xtm_go = mor.xtm_en && ocr_sel == 3'h0;
    logic [11:0] xt_per;
    logic        xt_primed;
    logic [2:0]  xt_bad;
    wire xt_off   = xt_per < XT_LO || xt_per > XT_HI;
    wire xt_check = xtm_go & xt_rise & xt_primed;
    wire xt_trip  = xt_check & xt_off & (xt_bad == BAD_RUN - 3'h1);
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !xtm_go) begin
            xt_per    <= 12'h0;
            xt_primed <= 1'b0;
            xt_bad    <= 3'h0;
        end else if (xt_rise) begin
            xt_per    <= 12'h0;
            xt_primed <= 1'b1;
            if (xt_check)
                xt_bad <= !xt_off ? 3'h0 :
                          (xt_bad == BAD_RUN) ? xt_bad : xt_bad + 3'h1;
        end else if (xt_per != 12'hfff) begin
            xt_per <= xt_per + 12'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            xt_err <= 1'b0;
        else
            xt_err <= xt_trip | (xt_err & ~(wr_focr &
                      WDATA[`CSP_FOCR_XT_ERR] & ~mor.xtm_en));
    end

    // Status word and read mux
    logic [31:0] sr_word;
    always_comb begin
        sr_word = 32'h0;
        sr_word[`CSP_SR_XT_STABLE] = xt_stable;
        sr_word[`CSP_SR_LOCK]      = locked;
        sr_word[`CSP_SR_SEL_DONE]  = sel_done;
        sr_word[`CSP_SR_RC_STABLE] = rc_stable;
        sr_word[`CSP_SR_FD_EVENT]  = fd_event;
        sr_word[`CSP_SR_FD_STATUS] = fd_status;
        sr_word[`CSP_SR_FAULT]     = fault;
        sr_word[`CSP_SR_XT_ERR]    = xt_err;
    end

    wire [31:0] mor_word = {5'h0, mor.xtm_en, mor.fd_en, mor.xt_sel,
                            mor.xtst, 4'h0, mor.rc_en, 2'h0, mor.xt_en};
    wire [31:0] pll_word = {8'h0, pll.mul, 2'h0, pll.cnt, 1'b0, pll.div};
    wire [31:0] mcfr_word = {15'h0, mf_rdy, mf_cnt};
    wire [31:0] rd_mux =
        ADDR == `CSP_OFS_MOR  ? mor_word :
        ADDR == `CSP_OFS_MCKR ? {30'h0, clock_source_select} :
        ADDR == `CSP_OFS_PLL  ? pll_word :
        ADDR == `CSP_OFS_SR   ? sr_word :
        ADDR == `CSP_OFS_IER  ? ier :
        ADDR == `CSP_OFS_MCFR ? mcfr_word :
        ADDR == `CSP_OFS_OCR  ? {29'h0, ocr_sel} : 32'h0;

    // Only crystal stable, lock, failure event and crystal error reach the line
    wire [31:0] irq_src = sr_word & ier & ~((32'h1 << `CSP_SR_SEL_DONE) |
                          (32'h1 << `CSP_SR_RC_STABLE) |
                          (32'h1 << `CSP_SR_FD_STATUS) |
                          (32'h1 << `CSP_SR_FAULT));

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RDATA <= 32'h0;
            IRQ   <= 1'b0;
        end else begin
            RDATA <= RD ? rd_mux : 32'h0;
            IRQ   <= |irq_src;
        end
    end

    // Control outputs, registered one cycle behind their sources
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            MAIN_XTAL_EN     <= 1'b0;
            MAIN_SRC_CRYSTAL <= 1'b0;
            FAST_RC_EN       <= `CSP_MOR_RC_RST;
            SLOW_RC_EN       <= 1'b0;
            MCK_SRC          <= `CSP_CSS_MAIN;
            PLL_EN           <= 1'b0;
            PLL_DIV          <= 7'h0;
            PLL_MUL          <= 8'h0;
            FAULT_OUT        <= 1'b0;
        end else begin
            MAIN_XTAL_EN     <= mor.xt_en;
            MAIN_SRC_CRYSTAL <= sel_applied;
            FAST_RC_EN       <= mor.rc_en;
            SLOW_RC_EN       <= mor.fd_en;
            MCK_SRC          <= clock_source_select;
            PLL_EN           <= pll_on;
            PLL_DIV          <= pll.div;
            PLL_MUL          <= pll.mul;
            FAULT_OUT        <= fault;
        end
    end
endmodule : csp_top
`default_nettype wire

// file: tb/csp_top_sva.sv
// Concurrent checks on the clock supervision block ports
`timescale 1ns/100ps
`default_nettype none
module csp_top_sva (
    // Clock and reset
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    // Register port
    input wire logic [4:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        IRQ,
    // Clock controls
    input wire logic        MAIN_XTAL_EN,
    input wire logic        MAIN_SRC_CRYSTAL,
    input wire logic        FAST_RC_EN,
    input wire logic        SLOW_RC_EN,
    input wire logic [1:0]  MCK_SRC,
    input wire logic        PLL_EN,
    input wire logic [6:0]  PLL_DIV,
    input wire logic [7:0]  PLL_MUL,
    input wire logic        FAULT_OUT
);
    wire mor_wr = WR && ADDR == 5'h00;
    wire pll_wr = WR && ADDR == 5'h08;
    wire fo_clr = WR && ADDR == 5'h14 && WDATA[0];

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    chk_reset_values: assert property ($fell(SYS_RST) |->
        MCK_SRC == 2'h1 && FAST_RC_EN && !SLOW_RC_EN && !PLL_EN
        && !FAULT_OUT && !IRQ)
        else $error("reset values");
    chk_fd_rc_on: assert property (mor_wr |=> ##1
        SLOW_RC_EN == $past(WDATA[25], 2))
        else $error("slow RC enable");
    chk_pll_fields: assert property (pll_wr |=> ##1
        PLL_DIV == $past(WDATA[6:0], 2) && PLL_MUL == $past(WDATA[23:16], 2)
        && PLL_EN == (PLL_DIV != 7'h0 && PLL_MUL != 8'h0))
        else $error("PLL fields");
    chk_detect_gate: assert property ($rose(FAULT_OUT) |->
        $past(MAIN_XTAL_EN) && $past(SLOW_RC_EN))
        else $error("detector gate");
    chk_mck_fallback: assert property (
        $fell(MAIN_SRC_CRYSTAL) && FAULT_OUT |-> MCK_SRC == 2'h1)
        else $error("master fallback");
    chk_rc_takeover: assert property ($rose(FAULT_OUT) |->
        ##[0:800] (FAST_RC_EN && !MAIN_SRC_CRYSTAL))
        else $error("RC takeover");
    chk_fault_hold: assert property (
        FAULT_OUT && !fo_clr && !$past(fo_clr) |=> FAULT_OUT)
        else $error("fault hold");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data idle");
endmodule : csp_top_sva

bind csp_top csp_top_sva u_sva (
    .SYS_CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
    .MAIN_XTAL_EN, .MAIN_SRC_CRYSTAL, .FAST_RC_EN, .SLOW_RC_EN, .MCK_SRC,
    .PLL_EN, .PLL_DIV, .PLL_MUL, .FAULT_OUT
);
`default_nettype wire

// file: tb/csp_osc_model.sv
// Oscillator sources facing the clock supervision block
`timescale 1ns/100ps
`default_nettype none
module csp_osc_model #(
    parameter int MAIN_HALF_NS = 40,
    parameter int SLOW_HALF_NS = 2000
) (
    // Controls
    input  wire logic        xt_en,
    input  wire logic        main_run,
    input  wire logic [31:0] xt_half_ns,
    // Oscillator outputs
    output var  logic        main_clk,
    output var  logic        slow_rc,
    output var  logic        xtal32
);
    initial begin
        main_clk = 1'b0;
        slow_rc  = 1'b0;
        xtal32   = 1'b0;
    end
    // Stopped crystal stands low
    always begin
        #(MAIN_HALF_NS);
        main_clk = (xt_en && main_run) ? ~main_clk : 1'b0;
    end
    // Reference runs free
    always #(SLOW_HALF_NS) slow_rc = ~slow_rc;
    always begin
        #(xt_half_ns);
        xtal32 = ~xtal32;
    end
endmodule : csp_osc_model
`default_nettype wire

// file: tb/csp_top_tb_top.sv
// Self-checking bench for the clock supervision block
`timescale 1ns/100ps
`default_nettype none
`include "csp_consts.svh"
module csp_top_tb_top;
    localparam int SP = 200;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  addr = 5'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        main_run = 1'b1;
    logic [31:0] xt_half = 32'd500;
    wire  [31:0] rdata;
    wire  [6:0]  pll_div;
    wire  [7:0]  pll_mul;
    wire  [1:0]  mck_src;
    wire         irq, main_clk, slow_rc, xtal32, main_xtal_en, main_src;
    wire         fast_rc_en, slow_rc_en, pll_en, fault_out;
    int          err_count = 0;
    int          n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    // Nominal crystal period shortened to 50 cycles
    csp_top #(.REF_HZ(32768 * 50)) DUT (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .MAIN_CLK_IN(main_clk), .SLOW_RC_IN(slow_rc), .XTAL32_IN(xtal32),
        .MAIN_XTAL_EN(main_xtal_en), .MAIN_SRC_CRYSTAL(main_src),
        .FAST_RC_EN(fast_rc_en), .SLOW_RC_EN(slow_rc_en), .MCK_SRC(mck_src),
        .PLL_EN(pll_en), .PLL_DIV(pll_div), .PLL_MUL(pll_mul),
        .FAULT_OUT(fault_out)
    );
    csp_osc_model u_osc (
        .xt_en(main_xtal_en), .main_run(main_run), .xt_half_ns(xt_half),
        .main_clk(main_clk), .slow_rc(slow_rc), .xtal32(xtal32)
    );

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_rng(input logic [31:0] got, lo, hi);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : cmp_rng
    task automatic tmo();
        cmp(32'h0, 32'h1);
        conclude();
    endtask : tmo
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic wait_reg(input logic [4:0] a, input int b, output int cyc);
        logic [31:0] d = 32'h0;
        time         t0 = $time;
        for (int i = 0; i < 4000 && d[b] !== 1'b1; i++) rd_reg(a, d);
        if (d[b] !== 1'b1) tmo();
        cyc = int'(($time - t0) / 20);
    endtask : wait_reg
    task automatic rc_rise();
        for (int i = 0; i < SP && slow_rc; i++) settle(1);
        for (int i = 0; i < SP && !slow_rc; i++) settle(1);
        if (!slow_rc) tmo();
    endtask : rc_rise

    task automatic t_reset();
        logic [31:0] d;
        settle(1);
        cmp({mck_src, fast_rc_en, slow_rc_en, pll_en, fault_out, irq},
            32'h30);
        rd_reg(`CSP_OFS_MOR, d);
        cmp(d, 32'h8);
        rd_reg(`CSP_OFS_PLL, d);
        cmp(d, 32'h0);
        rd_reg(`CSP_OFS_SR, d);
        cmp({d[20:18], d[1]}, 32'h0);
        $display("reset done");
    endtask : t_reset
    task automatic t_gate();
        logic [31:0] d;
        wr_reg(`CSP_OFS_MOR, 32'h0200_0008);
        settle(1);
        cmp(slow_rc_en, 1'b1);
        settle(3 * SP);
        rd_reg(`CSP_OFS_SR, d);
        cmp({fault_out, d[20:18]}, 32'h0);
        $display("gate done");
    endtask : t_gate
    task automatic t_xtal();
        int c;
        wr_reg(`CSP_OFS_IER, 32'h1);
        wr_reg(`CSP_OFS_MOR, 32'h0000_0109);
        wait_reg(`CSP_OFS_SR, `CSP_SR_XT_STABLE, c);
        cmp_rng(c, 7 * SP, 9 * SP + 50);
        cmp(irq, 1'b1);
        wr_reg(`CSP_OFS_MOR, 32'h0100_0109);
        wait_reg(`CSP_OFS_SR, `CSP_SR_SEL_DONE, c);
        cmp(main_src, 1'b1);
        wr_reg(`CSP_OFS_IER, 32'h0);
        $display("xtal done");
    endtask : t_xtal
    task automatic t_freq();
        logic [31:0] d;
        int          c;
        wr_reg(`CSP_OFS_MCFR, 32'h0);
        wait_reg(`CSP_OFS_MCFR, `CSP_MCFR_RDY, c);
        rd_reg(`CSP_OFS_MCFR, d);
        cmp(d[16], 1'b1);
        cmp_rng(d[15:0], 760, 840);
        if (d[15:0] == 16'h0) wr_reg(`CSP_OFS_MOR, 32'h109);
        $display("freq done");
    endtask : t_freq
    task automatic t_pll();
        logic [31:0] v [3] = '{32'h0000_0201, 32'h00fe_0200, 32'h00fe_027f};
        logic [15:0] e [3] = '{16'h0001, 16'h7f00, 16'hff7f};
        logic [31:0] d;
        int          c;
        wr_reg(`CSP_OFS_PLL, 32'h0003_0201);
        settle(1);
        cmp({pll_en, pll_mul, pll_div}, 32'h8181);
        wait_reg(`CSP_OFS_SR, `CSP_SR_LOCK, c);
        cmp_rng(c, SP, 3 * SP + 50);
        wr_reg(`CSP_OFS_PLL, 32'h0003_0201);
        rd_reg(`CSP_OFS_SR, d);
        cmp(d[1], 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`CSP_OFS_PLL, v[i]);
            settle(1);
            cmp({pll_en, pll_mul, pll_div}, e[i]);
        end
        $display("pll done");
    endtask : t_pll
    task automatic t_fail_main();
        logic [31:0] d;
        int          n;
        wr_reg(`CSP_OFS_IER, 32'h0004_0000);
        wr_reg(`CSP_OFS_MOR, 32'h0300_0101);
        settle(3 * SP);
        cmp({fault_out, fast_rc_en}, 32'h0);
        rc_rise();
        main_run = 1'b0;
        for (n = 0; n < 1000 && main_src !== 1'b0; n++) settle(1);
        if (n == 1000) tmo();
        cmp_rng(n, SP - 10, 2 * SP + 20);
        settle(2);
        cmp({fault_out, fast_rc_en, irq}, 32'h7);
        // Restart so no fresh detection masks the clears
        main_run = 1'b1;
        settle(2 * SP);
        rd_reg(`CSP_OFS_SR, d);
        cmp({d[20], d[18]}, 32'h3);
        rd_reg(`CSP_OFS_SR, d);
        settle(1);
        cmp({d[18], irq, fault_out}, 32'h1);
        wr_reg(`CSP_OFS_FOCR, 32'h1);
        settle(1);
        cmp(fault_out, 1'b0);
        $display("fail main done");
    endtask : t_fail_main
    task automatic t_fail_pll();
        logic [31:0] d;
        int          n;
        int          m;
        wr_reg(`CSP_OFS_MOR, 32'h0300_0109);
        for (n = 0; n < 1000 && main_src !== 1'b1; n++) settle(1);
        wr_reg(`CSP_OFS_MCKR, 32'h2);
        settle(SP);
        cmp({main_src, mck_src}, 32'h6);
        rc_rise();
        main_run = 1'b0;
        for (n = 0; n < 1000 && mck_src === 2'h2; n++) settle(1);
        for (m = 0; m < 1000 && main_src !== 1'b0; m++) settle(1);
        if (n == 1000 || m == 1000) tmo();
        cmp(mck_src, 2'h1);
        cmp_rng(n + m, 2 * SP - 10, 3 * SP + 20);
        cmp_rng(m, SP - 10, SP + 10);
        main_run = 1'b1;
        settle(2 * SP);
        wr_reg(`CSP_OFS_FOCR, 32'h1);
        rd_reg(`CSP_OFS_SR, d);
        $display("fail pll done");
    endtask : t_fail_pll
    task automatic t_mon();
        logic [31:0] d;
        int          c;
        wr_reg(`CSP_OFS_OCR, 32'h0);
        wr_reg(`CSP_OFS_MOR, 32'h0400_0109);
        settle(10 * 50);
        rd_reg(`CSP_OFS_SR, d);
        cmp(d[21], 1'b0);
        xt_half = 32'd600;
        wait_reg(`CSP_OFS_SR, `CSP_SR_XT_ERR, c);
        cmp_rng(c, 3 * 60, 8 * 60 + 60);
        wr_reg(`CSP_OFS_IER, 32'h0020_0000);
        settle(1);
        cmp(irq, 1'b1);
        // Crystal back in range, flag must stay latched
        xt_half = 32'd500;
        wr_reg(`CSP_OFS_FOCR, 32'h2);
        rd_reg(`CSP_OFS_SR, d);
        cmp(d[21], 1'b1);
        wr_reg(`CSP_OFS_MOR, 32'h0000_0109);
        wr_reg(`CSP_OFS_FOCR, 32'h2);
        rd_reg(`CSP_OFS_SR, d);
        settle(1);
        cmp({d[21], irq}, 32'h0);
        $display("monitor done");
    endtask : t_mon

    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_gate();
        t_xtal();
        t_freq();
        t_pll();
        t_fail_main();
        t_fail_pll();
        t_mon();
        conclude();
    end
endmodule : csp_top_tb_top
`default_nettype wire
